/* rtl/chprot_cfg.svh */
/*
  Holds register offsets, field positions, reset values and codes of the
  channel protection block as macros.
  Assumes it is included by bare name, once per compilation unit.
*/
`ifndef CHPROT_CFG_SVH
`define CHPROT_CFG_SVH
// byte offsets on the register bus
`define OFF_CTRL 8'h00
`define OFF_MISC 8'h04
`define OFF_CLIPCFG 8'h08
`define OFF_PINCFG 8'h0c
`define OFF_ST12 8'h10
`define OFF_ST34 8'h14
`define OFF_STPWR 8'h18
`define OFF_STOTCS 8'h1c
`define OFF_STOTW 8'h20
`define OFF_MEM0 8'h24
`define OFF_IRQ_ST 8'h40
`define OFF_IRQ_EN 8'h44
`define OFF_IRQ_CLR 8'h48
// memory register slots, counted from OFF_MEM0
`define N_MEM 7
`define MEM_OCDC 0
`define MEM_PWR 1
`define MEM_OTCS 2
`define MEM_LDF 3
`define MEM_LDW 4
`define MEM_OTW 5
`define MEM_CLIP 6
// field positions
`define MISC_CLR_BIT 0
`define MISC_AUTO_BIT 1
`define POR_SEEN_BIT 7
`define N_IRQ 6
// reset values
`define RST_CTRL 8'h55
`define RST_CLIPCFG 8'h10
`define RST_PINCFG 12'h000
// reported channel state codes
`define REP_DIAGNOSTIC_STATE 3'h0
`define REP_HIZ 3'h1
`define REP_MUTE 3'h2
`define REP_PLAY 3'h3
`define REP_AR 3'h4
`define REP_PSD 3'h5
// requested channel modes
`define MODE_DIAGNOSTIC_STATE 2'h0
`define MODE_HIZ 2'h1
`define MODE_MUTE 2'h2
`define MODE_PLAY 2'h3
// clip group selections
`define GRP_12 2'h0
`define GRP_34 2'h1
`define GRP_ANY 2'h2
// fault pin and general pin codes
`define FPIN_FAULT 4'h0
`define FPIN_WARN 4'h1
`define FPIN_GRP1 4'h2
`define FPIN_GRP2 4'h3
`define GPIN_WARN 4'h1
`define GPIN_FAULT 4'h2
`define GPIN_GRP1 4'h3
`define GPIN_GRP2 4'h4
`define GPIN_HIGH 4'h6
`define GPIN_LOW 4'h7
`endif

/* rtl/chprot_pkg.sv */
/*
  Types of the channel protection block: the one-hot channel state.
  Assumes chprot_cfg.svh for codes; nothing else.
*/
`include "chprot_cfg.svh"
package chprot_pkg;
  typedef enum logic [5:0] {
    ST_DIAGNOSTIC_STATE = 6'h01,
    ST_HIZ = 6'h02,
    ST_MUTE = 6'h04,
    ST_PLAY = 6'h08,
    ST_AR = 6'h10,
    ST_PSD = 6'h20
  } ch_state_t;
endpackage

/* rtl/chprot.sv */
/*
  Four-channel protection state machines, clip groups, status, memory
  and interrupt registers behind an AHB-Lite slave.
  Assumes fault inputs come from analog detectors outside the clock
  domain; the clock is mclk_i at 100 MHz, reset synchronous active low.
*/
`timescale 1ns/10ps
`include "chprot_cfg.svh"
module chprot (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [3:0] clip_i,
  input wire logic [3:0] ocsd_i,
  input wire logic [3:0] dc_fault_i,
  input wire logic [3:0] load_fault_i,
  input wire logic [3:0] load_warn_i,
  input wire logic [3:0] ch_channel_overtemp_shutdown,
  input wire logic power_fault_i,
  input wire logic clk_invalid_i,
  input wire logic glob_channel_overtemp_shutdown,
  input wire logic otw_i,
  input wire logic foldback_i,
  output logic [3:0] drive_en_o,
  output logic [3:0] osc_run_o,
  output logic fault_pin_o,
  output logic fault_pin_oe_o,
  output logic [1:0] gpin_o,
  output logic [1:0] gpin_oe_o,
  output logic irq_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  // picks clip channels for a group; the fourth code selects none
  function automatic logic grp_sel(input logic [1:0] cfg, input logic [3:0] c);
    return (cfg == `GRP_12) ? |c[1:0] : (cfg == `GRP_34) ? |c[3:2] : ((cfg == `GRP_ANY) & (|c));
  endfunction

  // reported code of a state
  function automatic logic [2:0] rep(input chprot_pkg::ch_state_t s);
    logic [2:0] r;
    r = `REP_HIZ;
    if (s == chprot_pkg::ST_DIAGNOSTIC_STATE) r = `REP_DIAGNOSTIC_STATE;
    if (s == chprot_pkg::ST_MUTE) r = `REP_MUTE;
    if (s == chprot_pkg::ST_PLAY) r = `REP_PLAY;
    if (s == chprot_pkg::ST_AR) r = `REP_AR;
    if (s == chprot_pkg::ST_PSD) r = `REP_PSD;
    return r;
  endfunction

  // two-flop synchroniser for all detector inputs
  logic [28:0] raw;
  logic [28:0] s1_r;
  logic [28:0] s2_r;
  assign raw = {clip_i, ocsd_i, dc_fault_i, load_fault_i, load_warn_i, ch_channel_overtemp_shutdown,
                power_fault_i, clk_invalid_i, glob_channel_overtemp_shutdown, otw_i, foldback_i};
  always_ff @(posedge mclk_i) begin
    s1_r <= raw;
    s2_r <= s1_r;
  end

  logic [3:0] clip, ocsd, dcf, ldf, ldw, chot;
  logic pwr, clkbad, got, overtemp_warning, fold;
  assign {clip, ocsd, dcf, ldf, ldw, chot, pwr, clkbad, got, overtemp_warning, fold} = s2_r;

  // bus address phase
  logic acc, rd_acc, wr_acc;
  logic [7:0] ra;
  assign acc = hsel_i & htrans_i[1] & hready_i;
  assign rd_acc = acc & ~hwrite_i;
  assign wr_acc = acc & hwrite_i;
  assign ra = {haddr_i[7:2], 2'b00};

  logic wr_r;
  logic [7:0] wa_r;
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      wr_r <= 1'b0;
      wa_r <= 8'h00;
    end else begin
      wr_r <= wr_acc;
      wa_r <= ra;
    end
  end

  // data phase write strobes
  logic w_ctrl, w_misc, w_clip, w_pin, w_ien, w_iclr;
  assign w_ctrl = wr_r & (wa_r == `OFF_CTRL);
  assign w_misc = wr_r & (wa_r == `OFF_MISC);
  assign w_clip = wr_r & (wa_r == `OFF_CLIPCFG);
  assign w_pin = wr_r & (wa_r == `OFF_PINCFG);
  assign w_ien = wr_r & (wa_r == `OFF_IRQ_EN);
  assign w_iclr = wr_r & (wa_r == `OFF_IRQ_CLR);

  // configuration registers
  logic [7:0] ctrl_r, clipcfg_r, ien_r;
  logic [11:0] pincfg_r;
  logic auto_r, clr_r;
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ctrl_r <= `RST_CTRL;
      clipcfg_r <= `RST_CLIPCFG;
      pincfg_r <= `RST_PINCFG;
      ien_r <= 8'h00;
      auto_r <= 1'b0;
      clr_r <= 1'b0;
    end else begin
      if (w_ctrl) ctrl_r <= hwdata_i[7:0];
      if (w_clip) clipcfg_r <= hwdata_i[7:0];
      if (w_pin) pincfg_r <= hwdata_i[11:0];
      if (w_ien) ien_r <= hwdata_i[7:0];
      if (w_misc) auto_r <= hwdata_i[`MISC_AUTO_BIT];
      clr_r <= w_misc & hwdata_i[`MISC_CLR_BIT]; // one-cycle clear-fault
    end
  end

  // causes per channel: latched versus auto-recovering
  logic [3:0] lat_c, ar_c;
  assign lat_c = ocsd | ldf | dcf | ({4{~auto_r}} & (chot | {4{got}}));
  assign ar_c = {4{pwr | clkbad}} | ({4{auto_r}} & (chot | {4{got}}));

  chprot_pkg::ch_state_t st_r [4];
  chprot_pkg::ch_state_t st_nxt [4];
  logic [3:0] in_sd, in_psd, in_ar;

  // per-channel state machines
  for (genvar i = 0; i < 4; i++) begin : g_ch
    logic [1:0] mode;
    chprot_pkg::ch_state_t mode_st;
    assign mode = ctrl_r[2*i+1 -: 2];
    assign mode_st = (mode == `MODE_DIAGNOSTIC_STATE) ? chprot_pkg::ST_DIAGNOSTIC_STATE :
                     (mode == `MODE_MUTE) ? chprot_pkg::ST_MUTE :
                     (mode == `MODE_PLAY) ? chprot_pkg::ST_PLAY : chprot_pkg::ST_HIZ;
    assign in_psd[i] = st_r[i] == chprot_pkg::ST_PSD;
    assign in_ar[i] = st_r[i] == chprot_pkg::ST_AR;
    assign in_sd[i] = in_psd[i] | in_ar[i];

    always_comb begin
      st_nxt[i] = st_r[i];
      unique case (st_r[i])
        chprot_pkg::ST_PSD: begin
          if (clr_r) st_nxt[i] = chprot_pkg::ST_HIZ;
        end
        chprot_pkg::ST_AR: begin
          if (lat_c[i]) st_nxt[i] = chprot_pkg::ST_PSD;
          else if (!ar_c[i]) st_nxt[i] = mode_st;
        end
        chprot_pkg::ST_PLAY: begin
          if (lat_c[i]) st_nxt[i] = chprot_pkg::ST_PSD;
          else if (ar_c[i]) st_nxt[i] = chprot_pkg::ST_AR;
          else st_nxt[i] = mode_st;
        end
        chprot_pkg::ST_DIAGNOSTIC_STATE, chprot_pkg::ST_HIZ, chprot_pkg::ST_MUTE: begin
          st_nxt[i] = mode_st;
        end
        default: st_nxt[i] = chprot_pkg::ST_HIZ;
      endcase
    end

    always_ff @(posedge mclk_i) begin
      if (!rst_n_i) st_r[i] <= chprot_pkg::ST_HIZ;
      else st_r[i] <= st_nxt[i];
    end

    AST_PSD_HOLD: assert property (in_psd[i] && !clr_r |=> in_psd[i])
      else $error("latched shutdown left without clear-fault");
    AST_CLR_HIZ: assert property (in_psd[i] && clr_r |=> st_r[i] == chprot_pkg::ST_HIZ)
      else $error("clear-fault did not move channel to high impedance");
    AST_AR_BACK: assert property (in_ar[i] && !ar_c[i] && !lat_c[i] && mode == `MODE_PLAY
      |=> st_r[i] == chprot_pkg::ST_PLAY)
      else $error("auto shutdown did not return to play");
    AST_LAT_IN: assert property (st_r[i] == chprot_pkg::ST_PLAY && lat_c[i] |=> in_psd[i])
      else $error("latched cause did not enter latched shutdown");
    AST_AR_IN: assert property (st_r[i] == chprot_pkg::ST_PLAY && ar_c[i] && !lat_c[i]
      |=> in_ar[i])
      else $error("auto cause did not enter auto shutdown");
    AST_DRV_OFF: assert property (in_sd[i] |=> !drive_en_o[i])
      else $error("driver on while channel in shutdown");
  end

  // channel driver and oscillator outputs
  always_ff @(posedge mclk_i) begin
    for (int i = 0; i < 4; i++) begin
      drive_en_o[i] <= rst_n_i & (st_r[i] == chprot_pkg::ST_PLAY);
      osc_run_o[i] <= rst_n_i & (st_r[i] != chprot_pkg::ST_DIAGNOSTIC_STATE);
    end
  end

  // clip groups and internal signals
  logic grp1, grp2, fault_sig, warn_sig;
  assign grp1 = grp_sel(clipcfg_r[1:0], clip);
  assign grp2 = grp_sel(clipcfg_r[5:4], clip);
  assign fault_sig = |in_sd;
  assign warn_sig = overtemp_warning | fold;

  // fault pin: open drain for fault and warning, push-pull for groups
  logic [3:0] fcfg;
  logic f_o, f_oe;
  assign fcfg = pincfg_r[3:0];
  assign f_o = (fcfg == `FPIN_GRP1) ? grp1 : (fcfg == `FPIN_GRP2) ? grp2 : 1'b0;
  assign f_oe = (fcfg == `FPIN_FAULT) ? fault_sig : (fcfg == `FPIN_WARN) ? warn_sig :
                (fcfg == `FPIN_GRP1) | (fcfg == `FPIN_GRP2);

  // general pins
  logic [1:0] g_o, g_oe;
  for (genvar p = 0; p < 2; p++) begin : g_pin
    logic [3:0] c;
    assign c = pincfg_r[4*p+7 -: 4];
    assign g_o[p] = (c == `GPIN_GRP1) ? grp1 : (c == `GPIN_GRP2) ? grp2 :
                    (c == `GPIN_HIGH);
    assign g_oe[p] = (c == `GPIN_WARN) ? warn_sig : (c == `GPIN_FAULT) ? fault_sig :
                     (c == `GPIN_GRP1) | (c == `GPIN_GRP2) | (c == `GPIN_HIGH) |
                     (c == `GPIN_LOW);
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      fault_pin_o <= 1'b0;
      fault_pin_oe_o <= 1'b0;
      gpin_o <= 2'b00;
      gpin_oe_o <= 2'b00;
    end else begin
      fault_pin_o <= f_o;
      fault_pin_oe_o <= f_oe;
      gpin_o <= g_o;
      gpin_oe_o <= g_oe;
    end
  end

  AST_GRP_QUIET: assert property (clip == 4'h0 && pincfg_r[3:0] == `FPIN_GRP1
    |=> !fault_pin_o)
    else $error("clip group high without any clip warning");

  // memory registers: set by events, cleared on read, set wins
  logic [7:0] mem_r [`N_MEM];
  logic [7:0] mem_set [`N_MEM];
  logic [`N_MEM-1:0] mem_rd;
  assign mem_set[`MEM_OCDC] = {dcf, ocsd};
  assign mem_set[`MEM_PWR] = {7'h00, pwr};
  assign mem_set[`MEM_OTCS] = {2'b00, clkbad, got, chot};
  assign mem_set[`MEM_LDF] = {4'h0, ldf};
  assign mem_set[`MEM_LDW] = {4'h0, ldw};
  assign mem_set[`MEM_OTW] = {6'h00, fold, overtemp_warning};
  assign mem_set[`MEM_CLIP] = {4'h0, clip};
  for (genvar k = 0; k < `N_MEM; k++) begin : g_mem
    assign mem_rd[k] = rd_acc & (ra == `OFF_MEM0 + 8'(4 * k));
    always_ff @(posedge mclk_i) begin
      if (!rst_n_i) mem_r[k] <= (k == `MEM_PWR) ? 8'h80 : 8'h00;
      else mem_r[k] <= (mem_r[k] & {8{~mem_rd[k]}}) | mem_set[k];
    end
    AST_COR: assert property (mem_rd[k] && mem_set[k] == 8'h00 |=> mem_r[k] == 8'h00)
      else $error("memory register not cleared by read");
  end

  AST_POR: assert property ($past(!rst_n_i) |-> mem_r[`MEM_PWR][`POR_SEEN_BIT])
    else $error("power-on-reset-seen bit missing after reset");

  // interrupt status: sticky, write-one-to-clear, set wins
  logic [7:0] ist_r, iev;
  assign iev = {2'b00, ldw != 4'h0, overtemp_warning, pwr, clip != 4'h0, |in_ar, |in_psd};
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ist_r <= 8'h00;
      irq_o <= 1'b0;
    end else begin
      ist_r <= (ist_r & ~({8{w_iclr}} & hwdata_i[7:0])) | iev;
      irq_o <= |(ist_r & ien_r);
    end
  end

  // read mux, answered at the address phase edge
  logic [7:0] rmux;
  always_comb begin
    rmux = 8'h00;
    for (int k = 0; k < `N_MEM; k++) begin
      if (mem_rd[k]) rmux = mem_r[k];
    end
    case (ra)
      `OFF_CTRL: rmux = ctrl_r;
      `OFF_MISC: rmux = {6'h00, auto_r, 1'b0};
      `OFF_CLIPCFG: rmux = clipcfg_r;
      `OFF_PINCFG: rmux = pincfg_r[7:0];
      `OFF_ST12: rmux = {1'b0, rep(st_r[1]), 1'b0, rep(st_r[0])};
      `OFF_ST34: rmux = {1'b0, rep(st_r[3]), 1'b0, rep(st_r[2])};
      `OFF_STPWR: rmux = {7'h00, pwr};
      `OFF_STOTCS: rmux = {2'b00, clkbad, got, chot};
      `OFF_STOTW: rmux = {6'h00, fold, overtemp_warning};
      `OFF_IRQ_ST: rmux = ist_r;
      `OFF_IRQ_EN: rmux = ien_r;
      default: ;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      if (rd_acc) begin
        hrdata_o <= (ra == `OFF_PINCFG) ? {20'h00000, pincfg_r} : {24'h000000, rmux};
      end
    end
  end
endmodule

/* testbench/ahb_host.sv */
/*
  Host side model: an AHB-Lite master that polls and writes registers.
  Assumes one slave whose hreadyout is fed back as hready_i.
*/
`timescale 1ns/10ps
module ahb_host (
  input wire logic mclk_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_i,
  output logic hsel_o,
  output logic [31:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic hwrite_o,
  output logic [2:0] hsize_o,
  output logic [31:0] hwdata_o
);
  // bus idle at time zero
  initial begin
    hsel_o = 1'b0;
    haddr_o = 32'h0;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o = 3'h2;
    hwdata_o = 32'h0;
  end
  // one single word transfer, also used to poll status and write clear-fault
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
            output logic [31:0] q);
    @(posedge mclk_i);
    hsel_o <= 1'b1;
    haddr_o <= a;
    htrans_o <= 2'h2;
    hwrite_o <= w;
    hsize_o <= 3'h2;
    do @(posedge mclk_i); while (hready_i !== 1'b1);
    hsel_o <= 1'b0;
    htrans_o <= 2'h0;
    hwdata_o <= d;
    do @(posedge mclk_i); while (hready_i !== 1'b1);
    q = hrdata_i;
    hwdata_o <= ~d; // released data must not look valid
  endtask
endmodule

/* testbench/tb_top.sv */
/*
  Self-checking bench of the channel protection block.
  Assumes ahb_host as bus master and detector inputs driven here.
*/
`timescale 1ns/10ps
`include "chprot_cfg.svh"
module tb_top;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, fault_pin, fault_pin_oe, irq;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans, gpin, gpin_oe;
  logic [2:0] hsize;
  logic [3:0] clip_i = 4'h0, ocsd_i = 4'h0, ch_channel_overtemp_shutdown = 4'h0, drive_en, osc_run;
  logic [3:0] dc_fault_i = 4'h0;
  logic power_fault_i = 1'b0, glob_channel_overtemp_shutdown = 1'b0, otw_i = 1'b0;
  logic [5:0] pins, exp_pins;
  // pin drive values and enables in one word for the compare
  assign pins = {fault_pin_oe, fault_pin, gpin_oe, gpin};
  int num_errors, check_count, cyc, s, i;
  // clock and timeout
  always #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
  end
  ahb_host ahb_host_inst (.mclk_i(mclk_i), .hready_i(hreadyout), .hrdata_i(hrdata),
    .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite),
    .hsize_o(hsize), .hwdata_o(hwdata));
  chprot chprot_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hready_i(hreadyout),
    .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .clip_i(clip_i), .ocsd_i(ocsd_i), .dc_fault_i(dc_fault_i), .load_fault_i(4'h0),
    .load_warn_i(4'h0), .ch_channel_overtemp_shutdown(ch_channel_overtemp_shutdown), .power_fault_i(power_fault_i),
    .clk_invalid_i(1'b0), .glob_channel_overtemp_shutdown(glob_channel_overtemp_shutdown), .otw_i(otw_i), .foldback_i(1'b0),
    .drive_en_o(drive_en), .osc_run_o(osc_run), .fault_pin_o(fault_pin),
    .fault_pin_oe_o(fault_pin_oe), .gpin_o(gpin), .gpin_oe_o(gpin_oe), .irq_o(irq));
  // compare, bus and wait helpers
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    ahb_host_inst.xfer(1'b0, {24'h0, a}, 32'h0, q);
    chk(q, e);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    ahb_host_inst.xfer(1'b1, {24'h0, a}, d, q);
  endtask
  task idle(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  function automatic logic grp(input int sel, input logic [3:0] c);
    return (sel == 0) ? |c[1:0] : (sel == 1) ? |c[3:2] : |c;
  endfunction
  task end_sim();
    $display("comparisons %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    idle(20);
    rst_n_i <= 1'b1;
    rd(`OFF_CTRL, 32'h55);
    rd(`OFF_CLIPCFG, 32'h10);
    rd(`OFF_MEM0 + 8'h04, 32'h80);
    rd(`OFF_MEM0 + 8'h04, 32'h0);
    rd(`OFF_ST12, 32'h11);
    rd(8'h80, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    chk({28'h0, osc_run}, 32'hf);
    wr(`OFF_CTRL, 32'h0);
    idle(4);
    chk({28'h0, osc_run}, 32'h0);
    wr(`OFF_CTRL, 32'hff);
    idle(4);
    chk({28'h0, drive_en}, 32'hf);
    rd(`OFF_ST34, 32'h33);
    $display("test states done");
    wr(`OFF_PINCFG, 32'h432);
    wr(`OFF_IRQ_EN, 32'h4);
    for (s = 0; s < 3; s++) begin
      wr(`OFF_CLIPCFG, 32'((((s + 1) % 3) << 4) | s));
      for (i = 0; i < 4; i++) begin
        clip_i <= 4'h1 << i;
        idle(5);
        exp_pins = {1'b1, grp(s, clip_i), 2'b11, grp((s + 1) % 3, clip_i), grp(s, clip_i)};
        chk({26'h0, pins}, {26'h0, exp_pins});
      end
    end
    clip_i <= 4'h0;
    rd(`OFF_MEM0 + 8'h18, 32'hf);
    rd(`OFF_IRQ_ST, 32'h4);
    chk({31'h0, irq}, 32'h1);
    wr(`OFF_IRQ_CLR, 32'h4);
    idle(3);
    chk({31'h0, irq}, 32'h0);
    $display("test clip done");
    power_fault_i <= 1'b1;
    idle(5);
    chk({27'h0, irq, drive_en}, 32'h0);
    rd(`OFF_ST12, 32'h44);
    power_fault_i <= 1'b0;
    idle(5);
    chk({28'h0, drive_en}, 32'hf);
    rd(`OFF_MEM0 + 8'h04, 32'h1);
    wr(`OFF_MISC, 32'h2);
    ch_channel_overtemp_shutdown <= 4'h4;
    idle(5);
    rd(`OFF_ST34, 32'h34);
    ch_channel_overtemp_shutdown <= 4'h0;
    idle(5);
    rd(`OFF_ST34, 32'h33);
    $display("test auto done");
    ocsd_i <= 4'h1;
    idle(5);
    ocsd_i <= 4'h0;
    idle(8);
    rd(`OFF_ST12, 32'h35);
    rd(`OFF_MEM0, 32'h1);
    rd(`OFF_ST12, 32'h35);
    wr(`OFF_MISC, 32'h1);
    chk({28'h0, drive_en}, 32'he);
    idle(5);
    rd(`OFF_ST12, 32'h33);
    glob_channel_overtemp_shutdown <= 1'b1;
    idle(5);
    glob_channel_overtemp_shutdown <= 1'b0;
    idle(8);
    rd(`OFF_ST34, 32'h55);
    wr(`OFF_MISC, 32'h1);
    idle(5);
    chk({28'h0, drive_en}, 32'hf);
    $display("test latched done");
    wr(`OFF_PINCFG, 32'h721);
    otw_i <= 1'b1;
    dc_fault_i <= 4'h2;
    idle(5);
    chk({26'h0, pins}, 32'h2c);
    rd(`OFF_STOTW, 32'h1);
    otw_i <= 1'b0;
    dc_fault_i <= 4'h0;
    idle(4);
    rd(`OFF_MEM0 + 8'h14, 32'h1);
    rd(`OFF_MEM0, 32'h20);
    rd(`OFF_ST12, 32'h53);
    wr(`OFF_CTRL, 32'hfe);
    wr(`OFF_MISC, 32'h1);
    idle(5);
    rd(`OFF_ST12, 32'h32);
    chk({28'h0, drive_en}, 32'he);
    $display("test warn done");
    rst_n_i <= 1'b0;
    idle(2);
    rst_n_i <= 1'b1;
    chk({24'h0, drive_en, osc_run}, 32'h0);
    rd(`OFF_CTRL, 32'h55);
    rd(`OFF_MEM0 + 8'h04, 32'h80);
    rd(`OFF_ST12, 32'h11);
    $display("test reset done");
    end_sim();
  end
endmodule
